// ### hdl/swdlt_link.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Acknowledge handshake off after rstn reset; soft resets keep it.
// - Handshake-off command stops new acknowledge pulses; a running one finishes.
// - Low for 128 cycles or more means rate request.
// - Rate request waits for rising edge forever.
// - Rising edge after rate request soft-resets.
// - No falling edge in 512 cycles of a command soft-resets.
// - Same timeout between consecutive flash erases.
// - Timeout suppressed while mass erase pending.
// - Timeout drops partial command and read data.
// - Next falling edge starts new command.
// - Acknowledge and rate pulse clash tolerated.
module swdlt_link
    import swdlt_pkg::*;
(
    input  wire logic sys_clk,         // Debug serial clock, 200 MHz.
    input  wire logic rstn,            // Asynchronous reset, active low.
    input  wire logic background_pin_in,  // Background pin input level.
    output logic      background_pin_out, // Background pin output value.
    output logic      background_pin_oe,  // High while driving the pin.
    input  wire logic ack_enable_cmd,  // Handshake-on command pulse.
    input  wire logic ack_disable_cmd, // Handshake-off command pulse.
    input  wire logic ack_request,     // Command finished, acknowledge wanted.
    input  wire logic erase_pending,   // Flash mass erase still running.
    input  wire logic cmd_active,      // A command or read-out is in progress.
    output logic      cmd_fall,        // Falling edge for the command decoder.
    output logic      cmd_rise,        // Rising edge for the command decoder.
    output logic      sync_detect,     // Pulse when a rate request is seen.
    output logic      sync_done,       // Pulse when the rate request ends.
    output logic      soft_reset,      // Pulse that discards the command.
    output logic      timeout_flag,    // Pulse when the gap timeout fired.
    output logic      ack_enabled      // Handshake state.
);
    swdlt_edge_if edges ();

    swdlt_sync u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin_in  (background_pin_in),
        .edges   (edges)
    );

    swdlt_state_t state_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] gap_cnt_q;
    logic             ack_en_q;
    logic [CNT_W-1:0] ack_cnt_q;
    logic             soft_q;
    logic             tmo_q;
    logic             sdet_q;
    logic             sdone_q;
    logic             fall_q;
    logic             rise_q;
    logic             tmo_hit;
    logic             sync_hit;

    // Low-time threshold: reaching the count means a rate request.
    assign sync_hit = (state_q == SWDLT_LOW) && (low_cnt_q >= CNT_SYNC);
    // Erase pending holds off the gap timeout entirely.
    assign tmo_hit = (gap_cnt_q >= CNT_TMO) && !erase_pending && cmd_active;

    // Pulse framing state.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SWDLT_IDLE;
        end else begin
            case (state_q)
                SWDLT_IDLE: begin
                    if (edges.fall) begin
                        state_q <= SWDLT_LOW;
                    end
                end
                SWDLT_LOW: begin
                    if (sync_hit) begin
                        state_q <= SWDLT_SYNC;
                    end else if (edges.rise) begin
                        state_q <= SWDLT_HIGH;
                    end
                end
                SWDLT_SYNC: begin
                    // No timeout here: the host may hold the pin low indefinitely.
                    if (edges.rise) begin
                        state_q <= SWDLT_IDLE;
                    end
                end
                SWDLT_HIGH: begin
                    if (edges.fall) begin
                        state_q <= SWDLT_LOW;
                    end else if (tmo_hit || !cmd_active) begin
                        state_q <= SWDLT_IDLE;
                    end
                end
                default: begin
                    state_q <= SWDLT_IDLE;
                end
            endcase
        end
    end

    // Low-time counter, restarts on every falling edge.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_q <= '0;
        end else if (edges.fall) begin
            low_cnt_q <= CNT_W'(1);
        end else if (state_q == SWDLT_LOW && low_cnt_q != CNT_SYNC) begin
            low_cnt_q <= low_cnt_q + CNT_W'(1);
        end
    end

    // Gap counter between falling edges; saturates so it never wraps.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt_q <= '0;
        end else if (edges.fall || tmo_hit || state_q == SWDLT_SYNC) begin
            gap_cnt_q <= '0;
        end else if (gap_cnt_q != CNT_TMO) begin
            gap_cnt_q <= gap_cnt_q + CNT_W'(1);
        end
    end

    // Soft reset from either source, one pulse each.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            soft_q  <= 1'b0;
            tmo_q   <= 1'b0;
            sdet_q  <= 1'b0;
            sdone_q <= 1'b0;
            fall_q  <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            sdone_q <= (state_q == SWDLT_SYNC) && edges.rise;
            tmo_q   <= tmo_hit && !edges.fall;
            soft_q  <= ((state_q == SWDLT_SYNC) && edges.rise) || (tmo_hit && !edges.fall);
            sdet_q  <= sync_hit;
            fall_q  <= edges.fall && state_q != SWDLT_SYNC;
            rise_q  <= edges.rise && state_q == SWDLT_LOW && !sync_hit;
        end
    end

    // Handshake enable; off after reset, a disable wins a clash.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_en_q <= ACK_EN_RESET;
        end else if (ack_disable_cmd) begin
            ack_en_q <= 1'b0;
        end else if (ack_enable_cmd) begin
            ack_en_q <= 1'b1;
        end
    end

    // Acknowledge pulse drive. No arbitration against a host rate pulse:
    // the clash is rare and the open-drain style pin tolerates it.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_cnt_q <= '0;
        end else if (ack_request && ack_en_q && ack_cnt_q == '0) begin
            ack_cnt_q <= CNT_ACK;
        end else if (ack_cnt_q != '0) begin
            ack_cnt_q <= ack_cnt_q - CNT_W'(1);
        end
    end

    // The pin is only ever pulled low; the pull-up restores the high level.
    assign background_pin_out = 1'b0;
    assign background_pin_oe  = (ack_cnt_q != '0);
    assign cmd_fall     = fall_q;
    assign cmd_rise     = rise_q;
    assign sync_detect  = sdet_q;
    assign sync_done    = sdone_q;
    assign soft_reset   = soft_q;
    assign timeout_flag = tmo_q;
    assign ack_enabled  = ack_en_q;

    property p_ack_off_reset;
        @(posedge sys_clk) $rose(rstn) |-> !ack_enabled;
    endproperty
    a_ack_off_reset: assert property (p_ack_off_reset) else $error("handshake on after reset");

    property p_ack_disable;
        @(posedge sys_clk) disable iff (!rstn) ack_disable_cmd |=> !ack_enabled;
    endproperty
    a_ack_disable: assert property (p_ack_disable) else $error("handshake not turned off");

    property p_no_ack_when_off;
        @(posedge sys_clk) disable iff (!rstn)
            (!ack_enabled && !background_pin_oe) |=> !background_pin_oe;
    endproperty
    a_no_ack_when_off: assert property (p_no_ack_when_off) else $error("ack while off");

    property p_sync_detect;
        @(posedge sys_clk) disable iff (!rstn)
            (state_q == SWDLT_LOW && low_cnt_q == CNT_SYNC) |=> sync_detect ##0 state_q == SWDLT_SYNC;
    endproperty
    a_sync_detect: assert property (p_sync_detect) else $error("rate request missed");

    property p_sync_wait;
        @(posedge sys_clk) disable iff (!rstn)
            (state_q == SWDLT_SYNC && !edges.rise) |=> state_q == SWDLT_SYNC && !soft_reset;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("rate wait left early");

    property p_sync_soft;
        @(posedge sys_clk) disable iff (!rstn)
            (state_q == SWDLT_SYNC && edges.rise) |=> soft_reset && sync_done;
    endproperty
    a_sync_soft: assert property (p_sync_soft) else $error("no soft reset after rate");

    property p_timeout;
        @(posedge sys_clk) disable iff (!rstn)
            (gap_cnt_q == CNT_TMO && !erase_pending && cmd_active && !edges.fall)
            |=> soft_reset && timeout_flag;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

    property p_erase_hold;
        @(posedge sys_clk) disable iff (!rstn) erase_pending |=> !timeout_flag;
    endproperty
    a_erase_hold: assert property (p_erase_hold) else $error("timeout during erase");

    property p_fall_clears;
        @(posedge sys_clk) disable iff (!rstn) edges.fall |=> gap_cnt_q == '0;
    endproperty
    a_fall_clears: assert property (p_fall_clears) else $error("gap not cleared");

    // A timeout in the middle of a command must bring the framing back to idle.
    property p_tmo_drop;
        @(posedge sys_clk) disable iff (!rstn)
            (tmo_hit && !edges.fall && state_q == SWDLT_HIGH) |=> state_q == SWDLT_IDLE;
    endproperty
    a_tmo_drop: assert property (p_tmo_drop) else $error("partial command kept");

    // From idle, a falling edge always opens a fresh command.
    property p_new_cmd;
        @(posedge sys_clk) disable iff (!rstn)
            (state_q == SWDLT_IDLE && edges.fall) |=> state_q == SWDLT_LOW && cmd_fall;
    endproperty
    a_new_cmd: assert property (p_new_cmd) else $error("new command not started");

    // Once started, the acknowledge pulse runs to its end whatever the host does.
    property p_ack_hold;
        @(posedge sys_clk) disable iff (!rstn)
            (background_pin_oe && ack_cnt_q != CNT_W'(1)) |=> background_pin_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack pulse cut short");

    // While an erase is pending the saturated gap count must not reset the link.
    property p_erase_sat;
        @(posedge sys_clk) disable iff (!rstn)
            (erase_pending && gap_cnt_q == CNT_TMO) |=> gap_cnt_q == CNT_TMO && !soft_reset;
    endproperty
    a_erase_sat: assert property (p_erase_sat) else $error("erase gap not held");

    // The rising edge that ends a rate request is not command data.
    property p_sync_quiet;
        @(posedge sys_clk) disable iff (!rstn)
            (state_q == SWDLT_SYNC && edges.rise) |=> !cmd_rise;
    endproperty
    a_sync_quiet: assert property (p_sync_quiet) else $error("rate end seen as data");

    // Main scenarios worth seeing at least once.
    c_sync: cover property (@(posedge sys_clk) disable iff (!rstn) sync_done);
    c_tmo: cover property (@(posedge sys_clk) disable iff (!rstn) timeout_flag);
    c_ack: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(background_pin_oe));
    c_erase: cover property (@(posedge sys_clk) disable iff (!rstn)
        erase_pending && gap_cnt_q == CNT_TMO);
    c_fresh: cover property (@(posedge sys_clk) disable iff (!rstn)
        state_q == SWDLT_IDLE && edges.fall);
endmodule
`default_nettype wire

// ### hdl/swdlt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module swdlt_sync (
    input  wire logic sys_clk,   // Debug serial clock.
    input  wire logic rstn,      // Asynchronous reset, active low.
    input  wire logic pin_in,    // Raw background pin level.
    swdlt_edge_if.src edges      // Filtered level and edges.
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // Three stages; a change counts once the second and third agree.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            lvl_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end

    // Edges are pulses in the cycle before the filtered level changes.
    assign edges.pin_level = lvl_q;
    assign edges.fall = lvl_q & (s2_q == s3_q) & ~s3_q;
    assign edges.rise = ~lvl_q & (s2_q == s3_q) & s3_q;
endmodule
`default_nettype wire

// ### inc/swdlt_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface swdlt_edge_if;
    logic pin_level;
    logic fall;
    logic rise;
    modport src (output pin_level, output fall, output rise);
    modport dst (input pin_level, input fall, input rise);
endinterface
`default_nettype wire

// ### inc/swdlt_pkg.sv
`default_nettype none
package swdlt_pkg;
    // Cycle counts on the debug serial clock.
    localparam int unsigned SYNC_LOW_CYCLES = 128;
    localparam int unsigned TIMEOUT_CYCLES  = 512;
    localparam int unsigned READ_DELAY_CYCLES = 16;
    localparam int unsigned ACK_PULSE_CYCLES = 16;
    localparam int unsigned CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_SYNC = CNT_W'(SYNC_LOW_CYCLES);
    localparam logic [CNT_W-1:0] CNT_TMO  = CNT_W'(TIMEOUT_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ACK  = CNT_W'(ACK_PULSE_CYCLES);
    localparam logic ACK_EN_RESET = 1'b0;
    typedef enum logic [1:0] {
        SWDLT_IDLE = 2'b00,
        SWDLT_LOW  = 2'b01,
        SWDLT_SYNC = 2'b11,
        SWDLT_HIGH = 2'b10
    } swdlt_state_t;
endpackage
`default_nettype wire

// ### tb/swdlt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host pod on the open-drain background pin; a pull-up holds the wire high.
module swdlt_host_model (
    input  wire logic sys_clk,  // Debug serial clock.
    input  wire logic tgt_oe,   // Target pulls the pin low.
    output logic      pin_level // Resolved wire level.
);
    logic host_oe = 1'b0;

    // Wired pull-down of both parties; a clash with an acknowledge is not prevented.
    assign pin_level = !(host_oe || tgt_oe);

    // Every transfer opens with a falling edge, then the pin is held low n cycles.
    task automatic low_pulse(input int n);
        @(posedge sys_clk) host_oe <= 1'b1;
        repeat (n) @(posedge sys_clk);
        host_oe <= 1'b0;
    endtask

    // Without acknowledge the host waits the worst case, stretched for a slow core.
    task automatic read_wait(input int ratio);
        repeat ((3 * ratio + 5 > 16) ? 3 * ratio + 5 : 16) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ### tb/swdlt_link_tb.sv
`timescale 1ns/1ps
`default_nettype none
module swdlt_link_tb;
    import swdlt_pkg::*;
    logic sys_clk, rstn, pin, oe, out, fall, rise, sdet, sdone, srst, tflag, acken;
    logic ack_en = 0, ack_dis = 0, ack_req = 0, erase = 0, active = 0;
    int   miscompares = 0, compares = 0, n_fall = 0, n_sdet = 0, n_sdone = 0;
    int   n_srst = 0, n_tflag = 0, n_rise = 0, n, s, d, f, r;

    swdlt_link DUT (.sys_clk(sys_clk), .rstn(rstn), .background_pin_in(pin),
        .background_pin_out(out), .background_pin_oe(oe),
        .ack_enable_cmd(ack_en), .ack_disable_cmd(ack_dis),
        .ack_request(ack_req), .erase_pending(erase), .cmd_active(active),
        .cmd_fall(fall), .cmd_rise(rise), .sync_detect(sdet), .sync_done(sdone),
        .soft_reset(srst), .timeout_flag(tflag), .ack_enabled(acken));
    swdlt_host_model HOST (.sys_clk(sys_clk), .tgt_oe(oe), .pin_level(pin));

    // Pulse tallies let each scenario judge what happened over a stretch of time.
    always @(posedge sys_clk) begin
        n_fall  += (fall === 1'b1);
        n_rise  += (rise === 1'b1);
        n_sdet  += (sdet === 1'b1);
        n_sdone += (sdone === 1'b1);
        n_srst  += (srst === 1'b1);
        n_tflag += (tflag === 1'b1);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Issue handshake commands, then request an acknowledge and count driven cycles.
    task automatic ack_try(input logic en, input logic dis, output int cnt);
        @(posedge sys_clk) begin ack_en <= en; ack_dis <= dis; end
        @(posedge sys_clk) begin ack_en <= 0; ack_dis <= 0; ack_req <= 1; end
        @(posedge sys_clk) ack_req <= 0;
        cnt = 0;
        repeat (30) @(posedge sys_clk) cnt += (oe === 1'b1);
    endtask

    task automatic t_ack;
        check(acken, 0);
        ack_try(0, 0, n); check(n, 0);
        ack_try(1, 0, n); check(n, ACK_PULSE_CYCLES);
        check(acken, 1);
        ack_try(1, 1, n); check(n, 0);
        check(acken, 0);
        ack_try(1, 0, n); ack_try(0, 1, n); check(n, 0);
    endtask

    // A low pulse of len cycles: one falling command edge, a rate request only if long.
    task automatic t_low(input int len, input int exp_sync);
        f = n_fall; d = n_sdet; r = n_rise;
        HOST.low_pulse(len);
        repeat (12) @(posedge sys_clk);
        check(n_fall - f, 1);
        check(n_rise - r, 1 - exp_sync);
        check(n_sdet - d, exp_sync);
    endtask

    // Long hold with an acknowledge clashing: no reset until the rising edge.
    task automatic t_sync;
        s = n_srst; d = n_sdet; f = n_sdone;
        active <= 1;
        fork
            HOST.low_pulse(700);
            begin
                ack_try(1, 0, n); check(n, ACK_PULSE_CYCLES);
                check(out, 0);
                repeat (650) @(posedge sys_clk);
                check(n_srst - s, 0);
                check(n_sdet - d, 1);
            end
        join
        repeat (10) @(posedge sys_clk);
        check(n_sdone - f, 1);
        check(n_srst - s, 1);
        active <= 0;
        ack_try(0, 1, n);
    endtask

    // Gap timeout measured from the host's falling edge, then erase suppression.
    task automatic t_timeout;
        active <= 1;
        s = n_srst; d = n_tflag;
        fork HOST.low_pulse(5); join_none
        n = 0;
        while (n_tflag == d && n < 700) @(posedge sys_clk) n++;
        check(n >= 512 && n <= 522, 1);
        check(n_srst - s, 1);
        t_low(5, 0);
        HOST.read_wait(1);
        erase <= 1; d = n_tflag;
        HOST.low_pulse(5);
        repeat (700) @(posedge sys_clk);
        check(n_tflag - d, 0);
        erase <= 0;
        repeat (20) @(posedge sys_clk);
        check(n_tflag - d, 1);
        active <= 0;
    endtask

    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The clock toggles every 2.5 ns, half of a 5 ns period.
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Watchdog sized well beyond the few thousand cycles the scenarios need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        complete_run;
    end

    initial begin
        rstn = 0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1;
        repeat (2) @(posedge sys_clk);
        t_ack;
        t_low(10, 0);
        t_low(120, 0);
        t_low(140, 1);
        t_sync;
        t_timeout;
        complete_run;
    end
endmodule
`default_nettype wire
